/* lcpi_pkg.sv */
// Shared constants and carrier types for the common polarity inversion block
package lcpi_pkg;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

    // Values after reset
    localparam logic POL_RESET = 1'b0;
    localparam logic CS_RESET = 1'b1;

    // Pin inputs after synchronisation
    typedef struct packed {
        logic polarity_toggle;
        logic chip_select;
        logic display_on;
    } lcpi_pins_t;

    // Number of pin inputs in the bundle
    localparam int PIN_WIDTH = $bits(lcpi_pins_t);

    // Serial command header flag that this block never looks at
    typedef struct packed {
        logic polarity_flag_bit;
    } lcpi_header_t;

endpackage

/* lcpi_sync.sv */
// Three-stage synchroniser with agreement filter for a bundle of pins
`timescale 1ns/1ps
module lcpi_sync #(
    parameter int WIDTH = lcpi_pkg::PIN_WIDTH,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Raw pins and filtered result
    input wire logic [WIDTH-1:0] pins_raw,
    output logic [WIDTH-1:0] pins_filt
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    // The stage chain below is written out for a three-stage filter
    if (WIDTH < 1 || lcpi_pkg::SYNC_STAGES != 3) begin : g_bad_cfg
        $error("lcpi_sync: unsupported WIDTH or stage count");
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit moves only once the second and third stage agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_agree
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    out_q[i] <= INIT[i];
                end else if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

    assign pins_filt = out_q;
endmodule // lcpi_sync

/* lcpi_core.sv */
// Common electrode polarity inversion driven by the hardware toggle pin
`timescale 1ns/1ps
// Contract
// - Inversion comes only from the hardware toggle input, never software.
// - While display-on is low, no polarity inversion takes place.
// - A rising edge of the toggle input while display-on is high arms a pending inversion.
// - The internal polarity state flips on each toggle rising edge while display-on is high.
// - With chip select high at arming, the change applies at its next fall; the core drops it instead if display-on goes low first.
// - With chip select low at arming, the change applies at once.
// - The polarity flag bit of the command header is ignored.
module lcpi_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pins from the host
    input wire logic polarity_toggle_input,
    input wire logic serial_chip_select,
    input wire logic display_on_input,
    // Header flag from the serial front end, unused
    input wire lcpi_pkg::lcpi_header_t cmd_header,
    // Panel bias and state view
    output logic common_electrode_polarity,
    output logic internal_polarity_state,
    output logic inversion_pending
);
    lcpi_pkg::lcpi_pins_t raw_pins;
    lcpi_pkg::lcpi_pins_t pins;
    logic toggle_prev_q;
    logic cs_prev_q;
    logic toggle_rise;
    logic cs_fall;
    logic pol_state_q;
    logic common_electrode_polarity_q;
    logic pending_q;
    logic hdr_unused;

    assign raw_pins = '{polarity_toggle: polarity_toggle_input,
                        chip_select: serial_chip_select,
                        display_on: display_on_input};

    // Pins reach the edge detectors four cycles after they move, so a
    // toggle or select pulse shorter than about two cycles may be lost;
    // the host pace is slow enough that this never matters.
    lcpi_sync #(
        .WIDTH(lcpi_pkg::PIN_WIDTH),
        .INIT({1'b0, lcpi_pkg::CS_RESET, 1'b0})
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pins_raw(raw_pins),
        .pins_filt(pins)
    );

    // Header flag deliberately discarded: inversion is hardware only
    assign hdr_unused = cmd_header.polarity_flag_bit;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            toggle_prev_q <= 1'b0;
            cs_prev_q <= lcpi_pkg::CS_RESET;
        end else begin
            toggle_prev_q <= pins.polarity_toggle;
            cs_prev_q <= pins.chip_select;
        end
    end

    assign toggle_rise = pins.polarity_toggle && !toggle_prev_q;
    assign cs_fall = cs_prev_q && !pins.chip_select;

    // Internal state flips on each toggle rise while the display is on
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pol_state_q <= lcpi_pkg::POL_RESET;
        end else if (toggle_rise && pins.display_on) begin
            pol_state_q <= !pol_state_q;
        end
        // Otherwise holds
    end

    // Pending change waits for a chip select fall, or applies if low
    // Two rises before one fall cancel out in the bias; the state keeps count
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (!pins.display_on) begin
            pending_q <= 1'b0;
        end else if (toggle_rise && pins.chip_select) begin
            pending_q <= 1'b1;
        end else if (cs_fall || !pins.chip_select) begin
            pending_q <= 1'b0;
        end
    end

    // Bias follows the state; a toggle arriving with CS low lands at once
    // Display off drops an armed change, so the bias may lag the state
    // until the next toggle; a blanked panel is never re-biased
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            common_electrode_polarity_q <= lcpi_pkg::POL_RESET;
        end else if (!pins.display_on) begin
            common_electrode_polarity_q <= common_electrode_polarity_q;
        end else if (toggle_rise && !pins.chip_select) begin
            common_electrode_polarity_q <= !pol_state_q;
        end else if (pending_q && cs_fall) begin
            common_electrode_polarity_q <= pol_state_q;
        end
    end

    assign common_electrode_polarity = common_electrode_polarity_q;
    assign internal_polarity_state = pol_state_q;
    assign inversion_pending = pending_q;

    // Checks on the registered state, seen through the filtered pins
    property p_state_flips;
        @(posedge core_clk) disable iff (!rst_n)
        (toggle_rise && pins.display_on)
            |=> (pol_state_q != $past(pol_state_q));
    endproperty
    a_state_flips: assert property (p_state_flips)
        else $error("polarity state did not flip on toggle rise");

    property p_state_holds;
        @(posedge core_clk) disable iff (!rst_n)
        !(toggle_rise && pins.display_on) |=> $stable(pol_state_q);
    endproperty
    a_state_holds: assert property (p_state_holds)
        else $error("polarity state changed without toggle rise");

    property p_off_frozen;
        @(posedge core_clk) disable iff (!rst_n)
        !pins.display_on |=> $stable(common_electrode_polarity_q) && $stable(pol_state_q);
    endproperty
    a_off_frozen: assert property (p_off_frozen)
        else $error("inversion while display off");

    property p_immediate;
        @(posedge core_clk) disable iff (!rst_n)
        (toggle_rise && !pins.chip_select && pins.display_on)
            |=> common_electrode_polarity_q == pol_state_q;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("bias not applied at once with chip select low");

    property p_arm;
        @(posedge core_clk) disable iff (!rst_n)
        (toggle_rise && pins.chip_select && pins.display_on)
            |=> pending_q && $stable(common_electrode_polarity_q);
    endproperty
    a_arm: assert property (p_arm)
        else $error("toggle rise did not arm pending change");

    property p_apply_on_fall;
        @(posedge core_clk) disable iff (!rst_n)
        (pending_q && cs_fall && pins.display_on && !toggle_rise)
            |=> common_electrode_polarity_q == pol_state_q && !pending_q;
    endproperty
    a_apply_on_fall: assert property (p_apply_on_fall)
        else $error("pending change not applied at chip select fall");

    property p_wait_cs;
        @(posedge core_clk) disable iff (!rst_n)
        (pending_q && pins.chip_select && !toggle_rise) |=> $stable(common_electrode_polarity_q);
    endproperty
    a_wait_cs: assert property (p_wait_cs)
        else $error("bias moved before chip select fell");

    property p_only_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        !toggle_rise && !pending_q |=> $stable(common_electrode_polarity_q);
    endproperty
    a_only_toggle: assert property (p_only_toggle)
        else $error("bias moved without a toggle");

    property p_off_clears;
        @(posedge core_clk) disable iff (!rst_n)
        !pins.display_on |=> !pending_q;
    endproperty
    a_off_clears: assert property (p_off_clears)
        else $error("pending change kept while display off");

    property p_cs_low_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (pins.display_on && !pins.chip_select) |=> !pending_q;
    endproperty
    a_cs_low_idle: assert property (p_cs_low_idle)
        else $error("change left pending with chip select low");

    property p_pend_holds;
        @(posedge core_clk) disable iff (!rst_n)
        (pending_q && pins.chip_select && pins.display_on)
            |=> pending_q;
    endproperty
    a_pend_holds: assert property (p_pend_holds)
        else $error("pending change lost before chip select fell");

    property p_arm_needs_rise;
        @(posedge core_clk) disable iff (!rst_n)
        (!toggle_rise && !pending_q) |=> !pending_q;
    endproperty
    a_arm_needs_rise: assert property (p_arm_needs_rise)
        else $error("change armed without a toggle rise");

    property p_rise_when_off;
        @(posedge core_clk) disable iff (!rst_n)
        (toggle_rise && !pins.display_on)
            |=> $stable(pol_state_q) && !pending_q;
    endproperty
    a_rise_when_off: assert property (p_rise_when_off)
        else $error("toggle rise acted while display off");

    property p_cs_rise_quiet;
        @(posedge core_clk) disable iff (!rst_n)
        (!cs_prev_q && pins.chip_select && !toggle_rise)
            |=> $stable(common_electrode_polarity_q) && $stable(pol_state_q);
    endproperty
    a_cs_rise_quiet: assert property (p_cs_rise_quiet)
        else $error("bias moved on a chip select rise");
endmodule // lcpi_core

/* lcpi_host_model.sv */
// Host-side model that drives the toggle and chip-select pins
`timescale 1ns/1ps
module lcpi_host_model (
    // Clock
    input wire logic core_clk,
    // Pins toward the panel
    output logic toggle_pin,
    output logic cs_pin
);
    initial begin
        toggle_pin = 1'b0;
        cs_pin = 1'b1;
    end
    // Equal halves give half duty; the period stays far below a second
    task automatic pulse(input int half);
        toggle_pin = 1'b1;
        repeat (half) @(negedge core_clk);
        toggle_pin = 1'b0;
        repeat (half) @(negedge core_clk);
    endtask
    // Select frames outnumber toggle rises over a run
    // Frames double as pixel rewrites, kept frequent
    task automatic cs_set(input logic v, input int len);
        cs_pin = v;
        repeat (len) @(negedge core_clk);
    endtask
endmodule // lcpi_host_model

/* tb.sv */
// Self-checking bench for the common polarity inversion core
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic display_on_input = 1'b1;
    lcpi_pkg::lcpi_header_t cmd_header = '0;
    logic toggle_pin;
    logic cs_pin;
    logic pol;
    logic st;
    logic pend;
    logic [2:0] exp_q[$];
    logic [2:0] prev;
    logic e_st = 1'b0;
    logic e_pol = 1'b0;
    logic e_pend = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int half;

    always #12.5 core_clk = ~core_clk;

    lcpi_host_model host (.core_clk(core_clk), .toggle_pin(toggle_pin),
        .cs_pin(cs_pin));
    lcpi_core u_lcpi_core (.core_clk(core_clk), .rst_n(rst_n),
        .polarity_toggle_input(toggle_pin), .serial_chip_select(cs_pin),
        .display_on_input(display_on_input), .cmd_header(cmd_header),
        .common_electrode_polarity(pol), .internal_polarity_state(st),
        .inversion_pending(pend));

    task automatic results();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: outputs %b expected %b", $time, got, exp);
        end
    endtask

    function automatic void note();
        exp_q.push_back({e_pol, e_st, e_pend});
    endfunction

    task automatic toggle(input int h);
        if (display_on_input) begin
            e_st = ~e_st;
            if (cs_pin) begin
                e_pend = 1'b1;
            end else begin
                e_pol = e_st;
                e_pend = 1'b0;
            end
            note();
        end
        host.pulse(h);
    endtask

    task automatic cs_to(input logic v);
        if (!v && cs_pin && e_pend) begin
            e_pol = e_st;
            e_pend = 1'b0;
            note();
        end
        host.cs_set(v, 10);
    endtask

    task automatic display_on_input_to(input logic v);
        if (!v && e_pend) begin
            e_pend = 1'b0;
            note();
        end
        display_on_input = v;
        repeat (10) @(negedge core_clk);
    endtask

    // The flag bit is noise the core must ignore
    always @(negedge core_clk) begin
        cmd_header.polarity_flag_bit = 1'($urandom);
    end

    // Any output change consumes the oldest expectation
    always @(negedge core_clk) begin
        if (!rst_n) begin
            prev = {pol, st, pend};
        end else if ({pol, st, pend} !== prev) begin
            prev = {pol, st, pend};
            if (exp_q.size() == 0) begin
                n_compared++;
                n_fail++;
                $display("Error at %0t: unexpected output change", $time);
            end else begin
                cmp(prev, exp_q.pop_front());
            end
        end
    end

    initial begin
        void'($urandom(32'h2c97));
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        cmp({pol, st, pend}, 3'h0);
        for (int i = 0; i < 6; i++) begin
            half = 8 + int'($urandom % 5);
            toggle(half);
            if (i % 3 == 1) toggle(half);
            cs_to(1'b0);
            toggle(half);
            cs_to(1'b1);
            repeat (3) begin
                cs_to(1'b0);
                cs_to(1'b1);
            end
        end
        toggle(9);
        display_on_input_to(1'b0);
        toggle(9);
        cs_to(1'b0);
        toggle(9);
        cs_to(1'b1);
        display_on_input_to(1'b1);
        toggle(9);
        cs_to(1'b0);
        cs_to(1'b1);
        n_compared++;
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("Error at %0t: expected changes never seen", $time);
        end
        results();
    end

    initial begin
        #150000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end
endmodule // tb
